// File: design/sfac_dev.sv
// Converter end: discrepancy latches, acknowledgment and stop reactions.
`timescale 1ns/1ps
module sfac_dev (
  input  wire logic       aclk,          // Control clock.
  input  wire logic       aresetn,       // Power-on reset, low.
  input  wire logic [1:0] mode,          // Commissioned function set.
  input  wire logic       lim_ramp_sel,  // Speed limit fault ramps.
  input  wire logic       dir_ramp_sel,  // Direction fault ramps.
  input  wire logic       ssm_active,    // Speed monitor running.
  input  wire logic       xchk_fault,    // Cross-check fault pulse.
  input  wire logic       alarm_event,   // Alarm-type event pulse.
  input  wire logic       motion_fault,  // Limit violation pulse.
  input  wire logic       standstill,    // Motor at rest.
  input  wire logic       ramp_exit,     // Motor left braking ramp.
  input  wire logic [3:0] disc_in,       // Discrepancy detected.
  output logic            torque_cut,    // Torque removed.
  output logic            ramp_stop,     // Quick-stop ramp braking.
  output logic            motor_on,      // Motor may run.
  output logic [3:0]      disc_flags,    // Latched discrepancies.
  output logic            fault_flag,    // Latched internal event.
  sfac_if.dev             link           // Link from the controller.
);
  logic [10:0]         s1_q, s2_q;
  logic [6:0]          lvl, act, actp_q, armed_q, armed_d, done;
  logic                primed_q;
  logic [3:0]          disc_q, disc_d, dclr, dmask;
  logic                fault_q, fault_d, lock_q, lock_d;
  logic                cut_q, cut_d, ramp_q, ramp_d, on_q, on_d;
  sfac_pkg::sfac_stop_t st_q, st_d;
  logic                tg_ok, ext_t, fs_ack;
  logic                sto_act, ss1_act, sls_act, sdi_act, mon_act;
  logic                req_cut, req_ramp, ev_set;
  logic [1:0]          lim_r;

  // Picks the reaction a limit fault gets from its commissioned setting.
  function automatic logic [1:0] lim_react(input logic on,
                                           input logic ramp);
    lim_react = {on & ~ramp, on & ramp};
  endfunction : lim_react

  assign torque_cut = cut_q;
  assign ramp_stop  = ramp_q;
  assign motor_on   = on_q;
  assign disc_flags = disc_q;
  assign fault_flag = fault_q;
  always_comb begin
    link.sw1 = '0;
    link.sw1[sfac_pkg::SW_CUT]  = cut_q;
    link.sw1[sfac_pkg::SW_RAMP] = ramp_q;
    link.sw1[sfac_pkg::SW_DISC] = |disc_q;
    link.sw1[sfac_pkg::SW_ON]   = on_q;
    link.sw1[sfac_pkg::SW_EVT]  = fault_q;
  end

  // ****************************************************
  // Input synchroniser
  // ****************************************************
  // The link may come from another board, so every bit passes
  // two flip-flops before anything looks at it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= sfac_pkg::SYNC_IDLE; // RL18
      s2_q <= sfac_pkg::SYNC_IDLE;
    end else begin
      s1_q <= {link.normal_stop, link.on_cmd,
               link.cw1[sfac_pkg::CW1_SS1], link.cw1[sfac_pkg::CW1_STO],
               link.cw1[sfac_pkg::CW_ACK], link.cw0[sfac_pkg::CW_ACK],
               link.fdi_ack, link.sel_n};
      s2_q <= s1_q;
    end
  end

  // ****************************************************
  // Pulse detectors
  // ****************************************************
  // A detector fires only after its line left idle and came back;
  // the synchroniser resets to idle, so a line already away from idle
  // at reset release is seen to leave idle and counts once it returns.
  always_comb begin
    lvl = {s2_q[sfac_pkg::SY_SS1G], s2_q[sfac_pkg::SY_STOG],
           s2_q[sfac_pkg::SY_SEL1], s2_q[sfac_pkg::SY_SEL0],
           s2_q[sfac_pkg::SY_CW17], s2_q[sfac_pkg::SY_ACKG],
           s2_q[sfac_pkg::SY_ACKT]};
    act  = lvl ^ sfac_pkg::DET_IDLE;
    done = armed_q & ~act & actp_q; // RL6 RL7 RL18
    armed_d = primed_q ? ((armed_q | (act & ~actp_q)) & ~done) : '0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      actp_q   <= '0;
      armed_q  <= '0;
      primed_q <= 1'b0;
    end else begin
      actp_q   <= act;
      armed_q  <= armed_d;
      primed_q <= 1'b1;
    end
  end

  // ****************************************************
  // Active functions and discrepancy latches
  // ****************************************************
  always_comb begin
    tg_ok = (mode == sfac_pkg::MODE_BASIC_TG_TERM) |
            (mode == sfac_pkg::MODE_EXT_TG_BASIC);
    ext_t = (mode == sfac_pkg::MODE_EXT_TERM);
    fs_ack = done[sfac_pkg::D_ACKT] | done[sfac_pkg::D_ACKG];
    // A discrepancy on the stop input selects the stop itself.
    sto_act = ~s2_q[sfac_pkg::SY_SEL0] | disc_q[sfac_pkg::DC_STO] |
              (tg_ok & ~s2_q[sfac_pkg::SY_STOG]);
    ss1_act = (ext_t & (~s2_q[sfac_pkg::SY_SEL1] |
                        disc_q[sfac_pkg::DC_SS1])) |
              ((mode == sfac_pkg::MODE_EXT_TG_BASIC) &
               ~s2_q[sfac_pkg::SY_SS1G]);
    sls_act = ext_t & (~s2_q[sfac_pkg::SY_SEL2] |
                       disc_q[sfac_pkg::DC_SLS]);
    sdi_act = ext_t & (~s2_q[sfac_pkg::SY_SEL3] |
                       disc_q[sfac_pkg::DC_SDI]);
    mon_act = ss1_act | sls_act | sdi_act | ssm_active;
    dmask = ext_t ? 4'hF : 4'h1;
    dclr  = '0;
    case (mode)
      sfac_pkg::MODE_BASIC_TERM:
        dclr[sfac_pkg::DC_STO] = done[sfac_pkg::D_STOT]; // RL1
      sfac_pkg::MODE_BASIC_TG_TERM:
        dclr[sfac_pkg::DC_STO] = done[sfac_pkg::D_STOT] |
                                 done[sfac_pkg::D_STOG] |
                                 done[sfac_pkg::D_CW17]; // RL2
      sfac_pkg::MODE_EXT_TERM: begin
        // Selecting the stop functions again must not hide these.
        dclr[sfac_pkg::DC_STO] = fs_ack; // RL3
        dclr[sfac_pkg::DC_SS1] = fs_ack; // RL3
        dclr[sfac_pkg::DC_SLS] = fs_ack | done[sfac_pkg::D_STOT] |
                                 done[sfac_pkg::D_SS1T]; // RL4
        dclr[sfac_pkg::DC_SDI] = dclr[sfac_pkg::DC_SLS]; // RL4
      end
      sfac_pkg::MODE_EXT_TG_BASIC:
        dclr[sfac_pkg::DC_STO] = done[sfac_pkg::D_STOT] |
                                 done[sfac_pkg::D_STOG] |
                                 done[sfac_pkg::D_SS1G] |
                                 done[sfac_pkg::D_CW17]; // RL5
      default: dclr = '0;
    endcase
    // A discrepancy still present wins over its own clear.
    disc_d = (disc_q & ~dclr) | (disc_in & dmask);
  end

  // ****************************************************
  // Stop reactions
  // ****************************************************
  always_comb begin
    req_cut  = xchk_fault; // RL17
    req_ramp = 1'b0;
    lim_r = lim_react(sls_act, lim_ramp_sel) | // RL12
            lim_react(sdi_act, dir_ramp_sel); // RL13
    if (alarm_event) begin
      req_cut  = req_cut | sto_act; // RL9 RL17
      req_ramp = ~sto_act & mon_act; // RL17
    end
    if (motion_fault) begin
      req_cut = req_cut | ss1_act | lim_r[1]; // RL11
      req_ramp = req_ramp | lim_r[0];
    end
    ev_set = req_cut | req_ramp;
    // Only a completed fail-safe pulse clears the event, and a
    // fresh event in that same cycle keeps it latched.
    fault_d = (fault_q & ~fs_ack) | ev_set;
    st_d = st_q;
    case (st_q)
      sfac_pkg::ST_RUN: begin
        if (req_cut) st_d = sfac_pkg::ST_CUT;
        else if (req_ramp) st_d = sfac_pkg::ST_RAMP;
      end
      sfac_pkg::ST_RAMP: begin
        if (req_cut | standstill | ramp_exit)
          st_d = sfac_pkg::ST_CUT; // RL16
        else if (fs_ack) st_d = sfac_pkg::ST_RUN;
      end
      sfac_pkg::ST_CUT: begin
        if (fs_ack & ~ev_set) st_d = sfac_pkg::ST_RUN;
      end
      default: st_d = sfac_pkg::ST_CUT;
    endcase
    // After an event the motor restarts only once a normal stop
    // has been given while running is allowed again.
    lock_d = ev_set |
             (lock_q & ~(s2_q[sfac_pkg::SY_NS] &
                         (st_q == sfac_pkg::ST_RUN) & ~fault_q));
    // Torque is cut from the next state as well as the request itself,
    // so the state machine adds no cycle before the cut.
    cut_d = (st_d == sfac_pkg::ST_CUT) | sto_act | req_cut; // RL15
    ramp_d = (st_d == sfac_pkg::ST_RAMP); // RL16
    on_d = s2_q[sfac_pkg::SY_ON] & ~s2_q[sfac_pkg::SY_NS] & ~lock_d &
           (st_d == sfac_pkg::ST_RUN) & ~cut_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disc_q  <= '0;
      fault_q <= 1'b0;
      lock_q  <= 1'b0;
      st_q    <= sfac_pkg::ST_RUN;
      cut_q   <= 1'b1;
      ramp_q  <= 1'b0;
      on_q    <= 1'b0;
    end else begin
      disc_q  <= disc_d;
      fault_q <= fault_d;
      lock_q  <= lock_d;
      st_q    <= st_d;
      cut_q   <= cut_d;
      ramp_q  <= ramp_d;
      on_q    <= on_d;
    end
  end
endmodule : sfac_dev

// File: design/sfac_pkg.sv
// Shared constants and types for the safety fault acknowledgment block.
// Overview of operation
// [RL1] Basic terminals: only SAFE_TORQUE_OFF select/deselect clears discrepancy.
// [RL2] Basic telegram: telegram SAFE_TORQUE_OFF or CW1 bit7 also.
// [RL3] Extended terminals: SAFE_TORQUE_OFF/SS1 discrepancy needs failsafe ack.
// [RL4] Extended terminals: SAFELY_LIMITED_SPEED/SAFE_DIRECTION cleared by SAFE_TORQUE_OFF, SS1, ack.
// [RL5] Extended telegram: telegram SAFE_TORQUE_OFF/SS1 or CW1 bit7.
// [RL6] Telegram ack is CW0 bit7 low-high-low.
// [RL7] Terminal ack is input low-high-low.
// [RL8] After SAFE_TORQUE_OFF event: deselect, stop, ack, on.
// [RL9] Event during monitoring gives internal-fault stop.
// [RL10] After SAFE_SPEED_MONITOR event: stop, ack, on.
// [RL11] Monitoring fault under SS1 cuts torque.
// [RL12] SAFELY_LIMITED_SPEED fault: cut or ramp per setting.
// [RL13] SAFE_DIRECTION fault: cut or ramp per setting.
// [RL14] After limit fault: deselect, stop, ack, on.
// [RL15] Torque cut acts without delay.
// [RL16] Ramp stop cuts at standstill or ramp exit.
// [RL17] Cross-check cuts; alarm depends on active function.
// [RL18] Synchronise inputs, detect whole pulse before clearing.
package sfac_pkg;
  typedef enum logic [1:0] {
    MODE_BASIC_TERM    = 2'b00,
    MODE_BASIC_TG_TERM = 2'b01,
    MODE_EXT_TERM      = 2'b10,
    MODE_EXT_TG_BASIC  = 2'b11
  } sfac_mode_t;
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_RAMP = 2'b01,
    ST_CUT  = 2'b10
  } sfac_stop_t;
  typedef enum logic [2:0] {
    C_IDLE  = 3'b000,
    C_DESEL = 3'b001,
    C_STOP  = 3'b010,
    C_HIGH  = 3'b011,
    C_LOW   = 3'b100,
    C_ON    = 3'b101
  } sfac_cseq_t;
  // Synchroniser vector layout and its idle levels.
  localparam int         SYNC_W    = 11;
  localparam int         SY_SEL0   = 0;
  localparam int         SY_SEL1   = 1;
  localparam int         SY_SEL2   = 2;
  localparam int         SY_SEL3   = 3;
  localparam int         SY_ACKT   = 4;
  localparam int         SY_ACKG   = 5;
  localparam int         SY_CW17   = 6;
  localparam int         SY_STOG   = 7;
  localparam int         SY_SS1G   = 8;
  localparam int         SY_ON     = 9;
  localparam int         SY_NS     = 10;
  localparam logic [10:0] SYNC_IDLE = 11'h18F;
  // Pulse detectors and the level each rests at.
  localparam int         DET_W     = 7;
  localparam int         D_ACKT    = 0;
  localparam int         D_ACKG    = 1;
  localparam int         D_CW17    = 2;
  localparam int         D_STOT    = 3;
  localparam int         D_SS1T    = 4;
  localparam int         D_STOG    = 5;
  localparam int         D_SS1G    = 6;
  localparam logic [6:0] DET_IDLE  = 7'h78;
  // Discrepancy flag positions.
  localparam int         DC_STO    = 0;
  localparam int         DC_SS1    = 1;
  localparam int         DC_SLS    = 2;
  localparam int         DC_SDI    = 3;
  // Telegram bit positions.
  localparam int         CW_ACK    = 7;
  localparam int         CW1_STO   = 0;
  localparam int         CW1_SS1   = 1;
  localparam int         SW_CUT    = 0;
  localparam int         SW_RAMP   = 1;
  localparam int         SW_DISC   = 2;
  localparam int         SW_ON     = 3;
  localparam int         SW_EVT    = 7;
  // Controller register map and fields.
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_CMD     = 8'h04;
  localparam logic [7:0] A_STAT    = 8'h08;
  localparam logic [7:0] A_ISTAT   = 8'h0C;
  localparam logic [7:0] A_IMASK   = 8'h10;
  localparam logic [7:0] CTRL_RST  = 8'hCF;
  localparam int         CT_ON     = 4;
  localparam int         CT_NS     = 5;
  localparam int         CT_STOG   = 6;
  localparam int         CT_SS1G   = 7;
  localparam int         CM_ACKT   = 0;
  localparam int         CM_ACKG   = 1;
  localparam int         CM_CW17   = 2;
  localparam int         CM_REC    = 3;
  localparam int         IQ_EVT    = 0;
  localparam int         IQ_DISC   = 1;
  localparam int         IQ_DONE   = 2;
  localparam int         IQ_CUT    = 3;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;
  // Each step of a controller sequence but C_ON lasts at least this long.
  localparam int         CLK_NS    = 4;
  localparam int         STEP_NS   = 200;
  localparam int         STEP_CYC  = (STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] STEP_LAST = 8'(STEP_CYC - 1);
endpackage : sfac_pkg

// File: design/sfac_if.sv
// Link between the safety controller and the converter's fault logic.
`timescale 1ns/1ps
interface sfac_if;
  logic [3:0] sel_n;
  logic       fdi_ack;
  logic [7:0] cw0;
  logic [7:0] cw1;
  logic       on_cmd;
  logic       normal_stop;
  logic [7:0] sw1;
  modport dev (
    input  sel_n,
    input  fdi_ack,
    input  cw0,
    input  cw1,
    input  on_cmd,
    input  normal_stop,
    output sw1
  );
  modport ctl (
    output sel_n,
    output fdi_ack,
    output cw0,
    output cw1,
    output on_cmd,
    output normal_stop,
    input  sw1
  );
endinterface : sfac_if

// File: design/sfac_ctl.sv
// Safety controller end: AXI4-Lite registers driving the link.
`timescale 1ns/1ps
module sfac_ctl (
  input  wire logic       aclk,    // Control clock.
  input  wire logic       aresetn, // Synchronous reset, low.
  input  wire logic [7:0] awaddr,  // Write address.
  input  wire logic       awvalid, // Write address valid.
  output logic            awready, // Write address ready.
  input  wire logic [31:0] wdata,  // Write data.
  input  wire logic [3:0] wstrb,   // Byte enables.
  input  wire logic       wvalid,  // Write data valid.
  output logic            wready,  // Write data ready.
  output logic [1:0]      bresp,   // Write response.
  output logic            bvalid,  // Write response valid.
  input  wire logic       bready,  // Write response ready.
  input  wire logic [7:0] araddr,  // Read address.
  input  wire logic       arvalid, // Read address valid.
  output logic            arready, // Read address ready.
  output logic [31:0]     rdata,   // Read data.
  output logic [1:0]      rresp,   // Read response.
  output logic            rvalid,  // Read data valid.
  input  wire logic       rready,  // Read data ready.
  output logic            irq,     // Level interrupt.
  sfac_if.ctl             link     // Link to the converter.
);
  logic [7:0]          awa_q, awa_d, wd_q, wd_d;
  logic                aw_q, aw_d, w_q, w_d, wok_q, wok_d;
  logic                bv_q, bv_d, rv_q, rv_d;
  logic [1:0]          br_q, br_d, rr_q, rr_d;
  logic [31:0]         rd_q, rd_d;
  logic [7:0]          ctrl_q, ctrl_d;
  logic [3:0]          ist_q, ist_d, imsk_q, imsk_d, ev;
  logic [7:0]          sw_q;
  logic [2:0]          pl_q, pl_d, ps_q, ps_d;
  logic                rec_q, rec_d;
  logic [7:0]          cnt_q, cnt_d;
  sfac_pkg::sfac_cseq_t st_q, st_d;
  logic                wr, cmd_go, tick;

  assign awready = ~aw_q & ~bv_q;
  assign wready  = ~w_q & ~bv_q;
  assign arready = ~rv_q;
  assign bvalid  = bv_q;
  assign bresp   = br_q;
  assign rvalid  = rv_q;
  assign rresp   = rr_q;
  assign rdata   = rd_q;
  assign irq     = |(ist_q & imsk_q);
  assign link.sel_n       = ctrl_q[3:0];
  assign link.on_cmd      = ctrl_q[sfac_pkg::CT_ON];
  assign link.normal_stop = ctrl_q[sfac_pkg::CT_NS];
  assign link.fdi_ack     = pl_q[sfac_pkg::CM_ACKT];
  assign link.cw0 = {pl_q[sfac_pkg::CM_ACKG], 7'h00};
  assign link.cw1 = {pl_q[sfac_pkg::CM_CW17], 5'h00,
                     ctrl_q[sfac_pkg::CT_SS1G], ctrl_q[sfac_pkg::CT_STOG]};

  // ****************************************************
  // Bus slave, registers and recovery sequencer
  // ****************************************************
  always_comb begin
    aw_d = aw_q; w_d = w_q; awa_d = awa_q; wd_d = wd_q; wok_d = wok_q;
    bv_d = bv_q & ~bready; br_d = br_q;
    rv_d = rv_q & ~rready; rr_d = rr_q; rd_d = rd_q;
    ctrl_d = ctrl_q; imsk_d = imsk_q; cmd_go = 1'b0;
    st_d = st_q; cnt_d = cnt_q; pl_d = pl_q; ps_d = ps_q; rec_d = rec_q;
    if (awvalid & awready) begin
      aw_d = 1'b1; awa_d = awaddr;
    end
    if (wvalid & wready) begin
      w_d = 1'b1; wd_d = wdata[7:0]; wok_d = wstrb[0];
    end
    wr = aw_q & w_q;
    ev = '0;
    ev[sfac_pkg::IQ_EVT]  = link.sw1[sfac_pkg::SW_EVT] &
                            ~sw_q[sfac_pkg::SW_EVT];
    ev[sfac_pkg::IQ_DISC] = link.sw1[sfac_pkg::SW_DISC] &
                            ~sw_q[sfac_pkg::SW_DISC];
    ev[sfac_pkg::IQ_CUT]  = link.sw1[sfac_pkg::SW_CUT] &
                            ~sw_q[sfac_pkg::SW_CUT];
    ist_d = ist_q;
    if (wr) begin
      aw_d = 1'b0; w_d = 1'b0; bv_d = 1'b1; br_d = sfac_pkg::RESP_OK;
      case (awa_q)
        sfac_pkg::A_CTRL:  if (wok_q) ctrl_d = wd_q;
        sfac_pkg::A_CMD:   cmd_go = wok_q & (st_q == sfac_pkg::C_IDLE);
        sfac_pkg::A_ISTAT: if (wok_q) ist_d = ist_q & ~wd_q[3:0];
        sfac_pkg::A_IMASK: if (wok_q) imsk_d = wd_q[3:0];
        sfac_pkg::A_STAT:  br_d = sfac_pkg::RESP_OK;
        default:           br_d = sfac_pkg::RESP_ERR;
      endcase
    end
    if (arvalid & arready) begin
      rv_d = 1'b1; rr_d = sfac_pkg::RESP_OK; rd_d = '0;
      case (araddr)
        sfac_pkg::A_CTRL:  rd_d[7:0] = ctrl_q;
        sfac_pkg::A_CMD:   rd_d = '0;
        sfac_pkg::A_STAT:  rd_d[8:0] = {st_q != sfac_pkg::C_IDLE, sw_q};
        sfac_pkg::A_ISTAT: rd_d[3:0] = ist_q;
        sfac_pkg::A_IMASK: rd_d[3:0] = imsk_q;
        default:           rr_d = sfac_pkg::RESP_ERR;
      endcase
    end
    // Each step but C_ON holds for STEP_CYC cycles so the far end's
    // synchroniser sees every level.
    tick = (cnt_q == sfac_pkg::STEP_LAST);
    cnt_d = tick ? '0 : cnt_q + 8'h01;
    case (st_q)
      sfac_pkg::C_IDLE: begin
        cnt_d = '0;
        if (cmd_go & wd_q[sfac_pkg::CM_REC]) begin
          st_d = sfac_pkg::C_DESEL; rec_d = 1'b1;
          ps_d = 3'h3;
        end else if (cmd_go & (|wd_q[2:0])) begin
          st_d = sfac_pkg::C_HIGH; rec_d = 1'b0; ps_d = wd_q[2:0];
        end
      end
      sfac_pkg::C_DESEL: begin
        ctrl_d[3:0] = 4'hF; // RL8
        ctrl_d[sfac_pkg::CT_STOG] = 1'b1; // RL14
        ctrl_d[sfac_pkg::CT_SS1G] = 1'b1;
        if (tick) st_d = sfac_pkg::C_STOP;
      end
      sfac_pkg::C_STOP: begin
        ctrl_d[sfac_pkg::CT_NS] = 1'b1; // RL10
        ctrl_d[sfac_pkg::CT_ON] = 1'b0;
        if (tick) st_d = sfac_pkg::C_HIGH;
      end
      sfac_pkg::C_HIGH: begin
        pl_d = ps_q; // RL6 RL7
        if (tick) st_d = sfac_pkg::C_LOW;
      end
      sfac_pkg::C_LOW: begin
        pl_d = '0;
        if (tick) begin
          st_d = rec_q ? sfac_pkg::C_ON : sfac_pkg::C_IDLE;
          ev[sfac_pkg::IQ_DONE] = ~rec_q;
        end
      end
      sfac_pkg::C_ON: begin
        ctrl_d[sfac_pkg::CT_NS] = 1'b0;
        ctrl_d[sfac_pkg::CT_ON] = 1'b1; // RL8
        st_d = sfac_pkg::C_IDLE; ev[sfac_pkg::IQ_DONE] = 1'b1;
      end
      default: st_d = sfac_pkg::C_IDLE;
    endcase
    // A new event wins over a clear written in the same cycle.
    ist_d = ist_d | ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0; w_q <= 1'b0; awa_q <= '0; wd_q <= '0; wok_q <= 1'b0;
      bv_q <= 1'b0; br_q <= '0; rv_q <= 1'b0; rr_q <= '0; rd_q <= '0;
      ctrl_q <= sfac_pkg::CTRL_RST; ist_q <= '0;
      // Follow the status in reset so release shows no false edge.
      imsk_q <= '0; sw_q <= link.sw1; pl_q <= '0; ps_q <= '0; rec_q <= 1'b0;
      cnt_q <= '0; st_q <= sfac_pkg::C_IDLE;
    end else begin
      aw_q <= aw_d; w_q <= w_d; awa_q <= awa_d; wd_q <= wd_d;
      wok_q <= wok_d; bv_q <= bv_d; br_q <= br_d; rv_q <= rv_d;
      rr_q <= rr_d; rd_q <= rd_d; ctrl_q <= ctrl_d;
      ist_q <= ist_d; imsk_q <= imsk_d; sw_q <= link.sw1; pl_q <= pl_d;
      ps_q <= ps_d; rec_q <= rec_d; cnt_q <= cnt_d; st_q <= st_d;
    end
  end
endmodule : sfac_ctl

// File: testbench/sfac_properties.sv
// Timing and framing checks on the link between the two ends.
`timescale 1ns/1ps
module sfac_properties (
  input wire logic       aclk,        // Clock.
  input wire logic       aresetn,     // Reset, low.
  input wire logic [3:0] sel_n,       // Selects.
  input wire logic       fdi_ack,     // Ack line.
  input wire logic [7:0] cw0,         // Word 0.
  input wire logic [7:0] cw1,         // Word 1.
  input wire logic       on_cmd,      // On.
  input wire logic       normal_stop, // Stop.
  input wire logic [7:0] sw1          // Status.
);
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  always_comb hi_d = fdi_ack ? hi_q + 8'h01 : 8'h00;
  always_ff @(posedge aclk) hi_q <= aresetn ? hi_d : 8'h00;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_ack_width;
    $fell(fdi_ack) |-> hi_q == sfac_pkg::STEP_LAST + 8'h01;
  endproperty
  a_ack_width: assert property (p_ack_width) else $error("ack width");
  property p_tg_width;
    $rose(cw0[sfac_pkg::CW_ACK]) |-> cw0[sfac_pkg::CW_ACK] [*8];
  endproperty
  a_tg_width: assert property (p_tg_width) else $error("tg ack width");
  property p_on_desel;
    $rose(on_cmd) |-> sel_n == 4'hF;
  endproperty
  a_on_desel: assert property (p_on_desel) else $error("on selected");
  property p_sw1_rsvd;
    sw1[6:4] == 3'h0;
  endproperty
  a_sw1_rsvd: assert property (p_sw1_rsvd) else $error("status bits");
  property p_stop_excl;
    !(sw1[sfac_pkg::SW_CUT] && sw1[sfac_pkg::SW_RAMP]);
  endproperty
  a_stop_excl: assert property (p_stop_excl) else $error("cut and ramp");
  property p_no_on;
    (!on_cmd) [*4] |-> !sw1[sfac_pkg::SW_ON];
  endproperty
  a_no_on: assert property (p_no_on) else $error("on without cmd");
  property p_stop_off;
    normal_stop [*4] |-> !sw1[sfac_pkg::SW_ON];
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("on in stop");
  property p_on_order;
    $rose(on_cmd) |-> $past(normal_stop);
  endproperty
  a_on_order: assert property (p_on_order) else $error("on order");
  c_ack: cover property ($rose(fdi_ack));
  c_tg: cover property ($rose(cw0[sfac_pkg::CW_ACK]));
  c_on: cover property ($rose(on_cmd));
endmodule : sfac_properties

// File: testbench/tb.sv
// Bench joining both ends of the acknowledgment link.
`timescale 1ns/1ps
module tb;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, rnd = 8'h14;
  logic [31:0] wdata = 32'h0, d, rdata;
  logic [3:0]  wstrb = 4'hF, disc_in = 4'h0, disc_flags;
  logic [2:0]  ev = 3'h0;
  logic [1:0]  mode = 2'h0, r, bresp, rresp;
  logic        lim_ramp_sel = 1'b0, ssm_active = 1'b0;
  logic        standstill = 1'b0, ramp_exit = 1'b0, ok;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        torque_cut, ramp_stop, motor_on, fault_flag;
  int          miscompares = 0, samples_checked = 0;
  sfac_if lnk ();
  sfac_ctl sfac_ctl_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .irq, .link(lnk));
  sfac_dev sfac_dev_i (.aclk, .aresetn, .mode, .lim_ramp_sel,
    .dir_ramp_sel(lim_ramp_sel), .ssm_active, .xchk_fault(ev[2]),
    .alarm_event(ev[1]), .motion_fault(ev[0]), .standstill, .ramp_exit,
    .disc_in, .torque_cut, .ramp_stop, .motor_on, .disc_flags,
    .fault_flag, .link(lnk));
  sfac_properties sfac_properties_i (.aclk, .aresetn, .sel_n(lnk.sel_n),
    .fdi_ack(lnk.fdi_ack), .cw0(lnk.cw0), .cw1(lnk.cw1),
    .on_cmd(lnk.on_cmd), .normal_stop(lnk.normal_stop), .sw1(lnk.sw1));
  always #2 aclk = ~aclk;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // Methods: term select, telegram select, word 1 pulse, two acks.
  function automatic logic exp_clr(input logic [1:0] md, input int m);
    if (md == 2'h2) return m > 2;
    if (md == 2'h0) return m == 0;
    return m < 3;
  endfunction : exp_clr
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
      miscompares++;
    end
  endtask : chk
  // Live outputs are looked at on the falling edge, clear of updates.
  task automatic chkn(input logic [31:0] g, input logic [31:0] e);
    @(negedge aclk);
    chk(g, e);
  endtask : chkn
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic aw, w, b;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    logic v;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(negedge aclk);
      ok = arvalid & arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ok) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : axr
  task automatic cmd(input logic [31:0] v);
    axw(sfac_pkg::A_CMD, v);
    d = 32'h100;
    while (d[8]) axr(sfac_pkg::A_STAT);
    tick(6);
  endtask : cmd
  task automatic pulse(input logic [2:0] p, input logic [3:0] q);
    @(posedge aclk);
    ev <= p;
    disc_in <= q;
    @(posedge aclk);
    ev <= 3'h0;
    disc_in <= 4'h0;
    tick(3);
  endtask : pulse
  task automatic rec();
    axw(sfac_pkg::A_CTRL, 32'hCF);
    cmd(32'h8);
    chkn(torque_cut, 32'h0);
    chkn(32'(motor_on), 32'h1);
  endtask : rec
  initial begin
    #160000;
    miscompares++;
    stop_test();
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      mode <= 2'(i ^ (i >> 1));
      aresetn <= 1'b0;
      tick(3);
      aresetn <= 1'b1;
      axr(sfac_pkg::A_CTRL);
      chk(d, 32'hCF);
      axr(8'h14);
      chk({30'h0, r}, 32'h2);
      axw(8'h14, 32'h0);
      chk({30'h0, r}, 32'h2);
      for (int m = 0; m < 5; m++) begin
        pulse(3'h0, 4'h1);
        chkn(32'(disc_flags[0]), 32'h1);
        if (m < 2) begin
          axw(sfac_pkg::A_CTRL, m ? 32'h8F : 32'hCE);
          tick(10);
          axw(sfac_pkg::A_CTRL, 32'hCF);
          tick(10);
        end else cmd(m == 2 ? 32'h4 : 32'(m - 2));
        chkn(32'(disc_flags[0]), 32'(!exp_clr(mode, m)));
        cmd(32'h1);
      end
    end
    axw(sfac_pkg::A_IMASK, 32'h8);
    rec();
    for (int f = 1; f < 4; f++) begin
      rnd = lfsr(rnd);
      axw(sfac_pkg::A_CTRL, 32'hCF & ~(32'h1 << f));
      lim_ramp_sel <= rnd[0];
      pulse(3'h1, 4'h0);
      chkn({ramp_stop, torque_cut}, (f > 1 && rnd[0]) ? 32'h2 : 32'h1);
      @(posedge aclk);
      standstill <= 1'b1;
      tick(3);
      standstill <= 1'b0;
      chkn(32'(torque_cut), 32'h1);
      chkn(32'(irq), 32'h1);
      axw(sfac_pkg::A_ISTAT, 32'hF);
      chkn(32'(irq), 32'h0);
      rec();
    end
    @(posedge aclk);
    ssm_active <= 1'b1;
    pulse(3'h2, 4'h0);
    chkn(32'(ramp_stop), 32'h1);
    chkn(32'(fault_flag), 32'h1);
    @(posedge aclk);
    ramp_exit <= 1'b1;
    tick(3);
    ramp_exit <= 1'b0;
    ssm_active <= 1'b0;
    chkn(32'(torque_cut), 32'h1);
    rec();
    pulse(3'h2, 4'h0);
    chkn({ramp_stop, torque_cut, fault_flag}, 32'h0);
    pulse(3'h4, 4'h0);
    chkn(32'(torque_cut), 32'h1);
    repeat (3) begin
      rnd = lfsr(rnd);
      axw(sfac_pkg::A_CTRL, {24'h0, rnd & 8'hCF});
      axr(sfac_pkg::A_CTRL);
      chk(d, {24'h0, rnd & 8'hCF});
    end
    stop_test();
  end
endmodule : tb
